// >>> common/clock_gate_pkg.sv
// shared constants for the peripheral clock gating block
package clock_gate_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_RUN_CLOCK_CONFIG = 12'h060;
    localparam logic [11:0] OFF_RUN_GATE_SET0 = 12'h100;
    localparam logic [11:0] OFF_RUN_GATE_SET1 = 12'h104;
    localparam logic [11:0] OFF_SLEEP_GATE_SET0 = 12'h110;
    localparam logic [11:0] OFF_SLEEP_GATE_SET1 = 12'h114;
    localparam logic [11:0] OFF_DEEP_SLEEP_GATE_SET0 = 12'h120;
    localparam logic [11:0] OFF_DEEP_SLEEP_GATE_SET1 = 12'h124;
    localparam logic [11:0] OFF_FAULT_STATUS = 12'h180;
    localparam logic [11:0] OFF_FAULT_MASK = 12'h184;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PWM_BIT = 20;
    localparam int HIBERNATE_GATE_BIT = 6;
    localparam int WATCHDOG_GATE_BIT = 3;
    localparam int COMPARATOR0_GATE_BIT = 24;
    localparam int COMPARATOR1_GATE_BIT = 25;
    localparam int COMPARATOR2_GATE_BIT = 26;
    localparam int AUTO_GATING_BIT = 0;

    // writable bits; everything else is reserved and reads zero
    localparam logic [31:0] SET0_MASK = 32'h0010_0048;
    localparam logic [31:0] SET1_MASK = 32'h0700_0000;
    localparam logic [31:0] CFG_MASK = 32'h0000_0001;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RUN_GATE_SET0_RST = 32'h0000_0000;
    localparam logic [31:0] RUN_GATE_SET1_RST = 32'h0000_0000;
    localparam logic [31:0] SLEEP_GATE_SET0_RST = 32'h0000_0040;
    localparam logic [31:0] SLEEP_GATE_SET1_RST = 32'h0000_0000;
    localparam logic [31:0] DEEP_SLEEP_GATE_SET0_RST = 32'h0000_0040;
    localparam logic [31:0] DEEP_SLEEP_GATE_SET1_RST = 32'h0000_0000;
    localparam logic [31:0] RUN_CLOCK_CONFIG_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // gated units: 0 pwm, 1 hibernate, 2 watchdog, 3..5 comparator 0..2
    // ------------------------------------------------------------
    localparam int NUM_UNITS = 6;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP
    } power_mode_t;

endpackage

// >>> verilog/peripheral_clock_gating.sv
// peripheral clock gating control with ahb-lite register slave
//
// Contract
// (R1) bit one: unit gets its clock
// (R2) bit zero: clock off; access faults
// (R3) gating bits reset to zero unless noted; sleep set0 bit 6 also resets to one (0x00000040)
// (R4) separate run, sleep, deep-sleep gate sets
// (R5) low-power sets apply only with auto gating
// (R6) deep set0 bit 20 gates pwm
// (R7) deep set0 bit 6 gates hibernate
// (R8) deep set0 bit 3 gates watchdog
// (R9) deep set0 resets to 0x00000040
// (R10) reserved bits read-only, read zero
// (R11) run set1 bits 26:24 gate comparators
// (R12) run set1 resets zero, reserved read zero
// (R13) software enables units before using them
// (R14) gate switching never truncates clock pulses
`timescale 1ns/1ps
`default_nettype none

module peripheral_clock_gating
    import clock_gate_pkg::*;
#(
    parameter int ADDR_BITS = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sleep_mode,
    input wire logic deep_sleep_mode,
    input wire logic [NUM_UNITS-1:0] periph_sel,
    output logic [NUM_UNITS-1:0] unit_clk_en,
    output logic bus_fault,
    output logic irq
);

    if (ADDR_BITS < 9 || ADDR_BITS > 32) begin : g_bad_addr
        $error("ADDR_BITS must lie between 9 and 32");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] run0;
        logic [31:0] run1;
        logic [31:0] slp0;
        logic [31:0] slp1;
        logic [31:0] dsl0;
        logic [31:0] dsl1;
        logic [31:0] cfg;
        logic [NUM_UNITS-1:0] stat;
        logic [NUM_UNITS-1:0] mask;
        logic [NUM_UNITS-1:0] clk_en;
        logic fault;
        logic wr_pend;
        logic [11:0] wr_addr;
        logic [31:0] rdata;
    } gate_state_t;

    gate_state_t s_r;
    gate_state_t s_nxt;

    localparam gate_state_t STATE_RST = '{
        run0: RUN_GATE_SET0_RST,
        run1: RUN_GATE_SET1_RST,
        slp0: SLEEP_GATE_SET0_RST,
        slp1: SLEEP_GATE_SET1_RST,
        dsl0: DEEP_SLEEP_GATE_SET0_RST,
        dsl1: DEEP_SLEEP_GATE_SET1_RST,
        cfg: RUN_CLOCK_CONFIG_RST,
        stat: '0,
        mask: '0,
        clk_en: '0,
        fault: 1'b0,
        wr_pend: 1'b0,
        wr_addr: 12'h000,
        rdata: 32'h0000_0000
    };

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [NUM_UNITS-1:0] unit_gates(
        input logic [31:0] set0,
        input logic [31:0] set1
    );
        unit_gates = {set1[COMPARATOR2_GATE_BIT], set1[COMPARATOR1_GATE_BIT], // (R11)
                      set1[COMPARATOR0_GATE_BIT], set0[WATCHDOG_GATE_BIT], // (R11) (R8)
                      set0[HIBERNATE_GATE_BIT], set0[PWM_BIT]}; // (R6) (R7)
    endfunction

    // reserved bits are never stored, so they read zero
    function automatic logic [31:0] read_word(
        input gate_state_t st,
        input logic [11:0] a
    );
        if (a == OFF_RUN_GATE_SET0) begin
            read_word = st.run0;
        end else if (a == OFF_RUN_GATE_SET1) begin
            read_word = st.run1; // (R10)
        end else if (a == OFF_SLEEP_GATE_SET0) begin
            read_word = st.slp0;
        end else if (a == OFF_SLEEP_GATE_SET1) begin
            read_word = st.slp1;
        end else if (a == OFF_DEEP_SLEEP_GATE_SET0) begin
            read_word = st.dsl0; // (R10)
        end else if (a == OFF_DEEP_SLEEP_GATE_SET1) begin
            read_word = st.dsl1;
        end else if (a == OFF_RUN_CLOCK_CONFIG) begin
            read_word = st.cfg;
        end else if (a == OFF_FAULT_STATUS) begin
            read_word = {{(32-NUM_UNITS){1'b0}}, st.stat};
        end else if (a == OFF_FAULT_MASK) begin
            read_word = {{(32-NUM_UNITS){1'b0}}, st.mask};
        end else begin
            read_word = 32'h0000_0000;
        end
    endfunction

    // ------------------------------------------------------------
    // gate set selection
    // ------------------------------------------------------------
    logic [NUM_UNITS-1:0] g_run;
    logic [NUM_UNITS-1:0] g_slp;
    logic [NUM_UNITS-1:0] g_dsl;
    logic [NUM_UNITS-1:0] fault_ev;
    logic [NUM_UNITS-1:0] stat_clr;
    logic [11:0] addr_lo;
    logic access;
    power_mode_t mode;

    assign g_run = unit_gates(s_r.run0, s_r.run1); // (R4)
    assign g_slp = unit_gates(s_r.slp0, s_r.slp1); // (R4)
    assign g_dsl = unit_gates(s_r.dsl0, s_r.dsl1); // (R4)
    assign addr_lo = {{(12-9){1'b0}}, haddr[8:0]} | (haddr[11:0] & 12'he00);
    assign access = hsel & htrans[1] & hready;

    always_comb begin
        // without auto gating the run set stays in charge
        if (!s_r.cfg[AUTO_GATING_BIT]) begin
            mode = MODE_RUN; // (R5)
        end else if (deep_sleep_mode) begin
            mode = MODE_DEEP; // (R5)
        end else if (sleep_mode) begin
            mode = MODE_SLEEP; // (R5)
        end else begin
            mode = MODE_RUN;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        stat_clr = '0;
        if (s_r.wr_pend) begin
            if (s_r.wr_addr == OFF_RUN_GATE_SET0) begin
                s_nxt.run0 = hwdata & SET0_MASK;
            end else if (s_r.wr_addr == OFF_RUN_GATE_SET1) begin
                s_nxt.run1 = hwdata & SET1_MASK; // (R10) (R11)
            end else if (s_r.wr_addr == OFF_SLEEP_GATE_SET0) begin
                s_nxt.slp0 = hwdata & SET0_MASK;
            end else if (s_r.wr_addr == OFF_SLEEP_GATE_SET1) begin
                s_nxt.slp1 = hwdata & SET1_MASK;
            end else if (s_r.wr_addr == OFF_DEEP_SLEEP_GATE_SET0) begin
                s_nxt.dsl0 = hwdata & SET0_MASK; // (R6) (R7) (R8) (R10)
            end else if (s_r.wr_addr == OFF_DEEP_SLEEP_GATE_SET1) begin
                s_nxt.dsl1 = hwdata & SET1_MASK;
            end else if (s_r.wr_addr == OFF_RUN_CLOCK_CONFIG) begin
                s_nxt.cfg = hwdata & CFG_MASK;
            end else if (s_r.wr_addr == OFF_FAULT_STATUS) begin
                stat_clr = hwdata[NUM_UNITS-1:0];
            end else if (s_r.wr_addr == OFF_FAULT_MASK) begin
                s_nxt.mask = hwdata[NUM_UNITS-1:0];
            end
        end
        // access to an unclocked unit is a fault
        fault_ev = periph_sel & ~s_r.clk_en; // (R2)
        s_nxt.fault = |fault_ev; // (R2)
        // a fault in the clearing cycle survives the clear
        s_nxt.stat = (s_r.stat & ~stat_clr) | fault_ev;
        // enables only move at a clock edge, so a gate never cuts a pulse
        case (mode)
            MODE_DEEP: s_nxt.clk_en = g_dsl; // (R14)
            MODE_SLEEP: s_nxt.clk_en = g_slp; // (R14)
            default: s_nxt.clk_en = g_run; // (R1) (R2) (R14)
        endcase
        s_nxt.wr_pend = access & hwrite;
        s_nxt.wr_addr = addr_lo;
        // read data built from the next state so a write just ahead is seen
        if (access && !hwrite) begin
            s_nxt.rdata = read_word(s_nxt, addr_lo);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= STATE_RST; // (R3) (R9) (R12)
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign unit_clk_en = s_r.clk_en;
    assign bus_fault = s_r.fault;
    assign irq = |(s_r.stat & s_r.mask);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic first_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ------------------------------------------------------------
    // checks: reset words
    // ------------------------------------------------------------
    a_reset_values: assert property ( // (R3)
        first_r |-> (s_r.run1 == RUN_GATE_SET1_RST) && (unit_clk_en == '0))
        else $error("gate set or enables not at reset value");
    a_deep_rst_word: assert property ( // (R9)
        first_r |-> s_r.dsl0 == DEEP_SLEEP_GATE_SET0_RST)
        else $error("deep-sleep set0 reset word wrong");
    a_other_rst_words: assert property ( // (R3)
        first_r |-> (s_r.run0 == RUN_GATE_SET0_RST) && (s_r.slp0 == SLEEP_GATE_SET0_RST)
        && (s_r.cfg == RUN_CLOCK_CONFIG_RST))
        else $error("other gate words not at reset value");

    // ------------------------------------------------------------
    // checks: set selection
    // ------------------------------------------------------------
    // enables settle one edge after the selected set or mode moves
    a_run_set_used: assert property ( // (R1)
        (!s_r.cfg[AUTO_GATING_BIT]) |=> unit_clk_en == $past(g_run))
        else $error("run set not applied");
    a_deep_set_used: assert property ( // (R5)
        (s_r.cfg[AUTO_GATING_BIT] && deep_sleep_mode) |=> unit_clk_en == $past(g_dsl))
        else $error("deep-sleep set not applied");
    a_sleep_set_used: assert property ( // (R4)
        (s_r.cfg[AUTO_GATING_BIT] && sleep_mode && !deep_sleep_mode)
        |=> unit_clk_en == $past(g_slp))
        else $error("sleep set not applied");
    a_run_set_steady: assert property ( // (R14)
        (!s_r.cfg[AUTO_GATING_BIT] && $past(!s_r.cfg[AUTO_GATING_BIT]) && $stable(g_run))
        |=> $stable(unit_clk_en))
        else $error("enable moved with no gate change");
    a_cfg_write: assert property ( // (R5)
        (s_r.wr_pend && s_r.wr_addr == OFF_RUN_CLOCK_CONFIG)
        |=> s_r.cfg == ($past(hwdata) & CFG_MASK))
        else $error("auto gating select write lost");

    // ------------------------------------------------------------
    // checks: faults and interrupt
    // ------------------------------------------------------------
    a_fault_raised: assert property ( // (R2)
        (|(periph_sel & ~unit_clk_en)) |=> bus_fault)
        else $error("access to unclocked unit gave no fault");
    a_no_false_fault: assert property ( // (R1)
        ((periph_sel & ~unit_clk_en) == '0) |=> !bus_fault)
        else $error("fault raised for a clocked unit");
    a_fault_pulse: assert property ( // (R2)
        bus_fault |-> ($past(periph_sel & ~unit_clk_en) != '0))
        else $error("fault raised with no access to an unclocked unit");
    a_status_clear: assert property ( // (R2)
        (s_r.wr_pend && s_r.wr_addr == OFF_FAULT_STATUS && fault_ev == '0)
        |=> (s_r.stat & $past(hwdata[NUM_UNITS-1:0])) == '0)
        else $error("fault status bit not cleared");
    a_mask_write: assert property ( // (R2)
        (s_r.wr_pend && s_r.wr_addr == OFF_FAULT_MASK)
        |=> s_r.mask == $past(hwdata[NUM_UNITS-1:0]))
        else $error("fault mask write lost");
    // a mask write in the same cycle may hide the fault, so it is left out
    a_irq_raised: assert property ( // (R2)
        (!s_r.wr_pend && ((fault_ev & s_r.mask) != '0))
        |=> irq)
        else $error("unmasked fault gave no interrupt");

    // ------------------------------------------------------------
    // checks: register bus
    // ------------------------------------------------------------
    a_reserved_zero: assert property ( // (R10)
        ((s_r.dsl0 & ~SET0_MASK) == 32'h0000_0000)
        && ((s_r.run1 & ~SET1_MASK) == 32'h0000_0000))
        else $error("reserved bit stored");
    a_deep_bits_write: assert property ( // (R6)
        (s_r.wr_pend && s_r.wr_addr == OFF_DEEP_SLEEP_GATE_SET0)
        |=> s_r.dsl0 == ($past(hwdata) & SET0_MASK))
        else $error("deep-sleep set0 write lost");
    a_comp_bits_write: assert property ( // (R11)
        (s_r.wr_pend && s_r.wr_addr == OFF_RUN_GATE_SET1)
        |=> s_r.run1[COMPARATOR2_GATE_BIT:COMPARATOR0_GATE_BIT]
        == $past(hwdata[COMPARATOR2_GATE_BIT:COMPARATOR0_GATE_BIT]))
        else $error("comparator gate write lost");
    a_fault_sticky: assert property ( // (R2)
        (fault_ev != '0) |=> ((s_r.stat & $past(fault_ev)) == $past(fault_ev)))
        else $error("fault status not captured");
    a_deep_read_zero: assert property ( // (R10)
        (access && !hwrite && addr_lo == OFF_DEEP_SLEEP_GATE_SET0)
        |=> (hrdata & ~SET0_MASK) == 32'h0000_0000)
        else $error("deep-sleep set0 reserved bit read nonzero");
    a_run1_read_zero: assert property ( // (R12)
        (access && !hwrite && addr_lo == OFF_RUN_GATE_SET1)
        |=> (hrdata & ~SET1_MASK) == 32'h0000_0000)
        else $error("run set1 reserved bit read nonzero");
    a_run1_read_back: assert property ( // (R11)
        (access && !hwrite && addr_lo == OFF_RUN_GATE_SET1 && !s_r.wr_pend)
        |=> hrdata == $past(s_r.run1))
        else $error("run set1 read data wrong");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    c_deep_gating: cover property (s_r.cfg[AUTO_GATING_BIT] && deep_sleep_mode ##1 1);
    c_sleep_gating: cover property (s_r.cfg[AUTO_GATING_BIT] && sleep_mode && !deep_sleep_mode);
    c_fault_seen: cover property (bus_fault);
    c_irq_seen: cover property (irq);
    c_unit_enabled: cover property ($rose(unit_clk_en[0]));

endmodule

`default_nettype wire

// >>> testbench/periph_model.sv
// stand-in for the gated peripheral units: issues accesses, counts faults
`timescale 1ns/1ps
`default_nettype none
module periph_model
    import clock_gate_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic go,
    input wire logic [2:0] unit,
    input wire logic bus_fault,
    output logic [NUM_UNITS-1:0] periph_sel,
    output var int fault_cnt
);
    // one access cycle per request, released at once so no access lingers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            periph_sel <= '0;
            fault_cnt <= 0;
        end else begin
            periph_sel <= go ? NUM_UNITS'(1) << unit : '0;
            if (bus_fault) begin
                fault_cnt <= fault_cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the peripheral clock gating block
`timescale 1ns/1ps
`default_nettype none
module testbench import clock_gate_pkg::*;;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic sleep_mode = 1'b0;
    logic deep_sleep_mode = 1'b0;
    logic go = 1'b0;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [2:0] unit = 3'd0;
    logic hready, hreadyout, hresp, bus_fault, irq;
    logic [NUM_UNITS-1:0] periph_sel, unit_clk_en;
    int error_cnt = 0;
    int check_count = 0;
    int faults;
    // ------------------------------------------------------------
    // write value, expected read-back
    // ------------------------------------------------------------
    row_t rows [5] = '{
        '{OFF_DEEP_SLEEP_GATE_SET0, 32'hFFFF_FFFF, 32'h0010_0048},
        '{OFF_DEEP_SLEEP_GATE_SET0, 32'h0000_0000, 32'h0000_0000},
        '{OFF_RUN_GATE_SET1, 32'hFFFF_FFFF, 32'h0700_0000},
        '{OFF_RUN_GATE_SET1, 32'h0200_0000, 32'h0200_0000},
        '{12'h0FC, 32'hFFFF_FFFF, 32'h0000_0000}};

    always #10 hclk = ~hclk;
    assign hready = hreadyout;

    peripheral_clock_gating i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode),
        .periph_sel(periph_sel), .unit_clk_en(unit_clk_en), .bus_fault(bus_fault),
        .irq(irq));
    periph_model i_model (.hclk(hclk), .hresetn(hresetn), .go(go), .unit(unit),
        .bus_fault(bus_fault), .periph_sel(periph_sel), .fault_cnt(faults));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // bounded wait; a slave that never answers ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            error_cnt++;
            $display("FAIL t=%0t bus hang", $time);
            conclude();
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        chk(32'(hresp), 32'h0);
    endtask
    // access lands on the unit one edge later, fault counted two edges after that
    task automatic access(input logic [2:0] u);
        go <= 1'b1;
        unit <= u;
        @(posedge hclk);
        go <= 1'b0;
        ticks(3);
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        ticks(5000);
        error_cnt++;
        $display("FAIL t=%0t run too long", $time);
        conclude();
    end
    initial begin
        ticks(20);
        hresetn <= 1'b1;
        bus(0, OFF_DEEP_SLEEP_GATE_SET0, 0);
        chk(q, 32'h0000_0040);
        bus(0, OFF_RUN_GATE_SET1, 0);
        chk(q, 32'h0000_0000);
        chk(32'(unit_clk_en), 32'h0);
        foreach (rows[i]) begin
            bus(1, rows[i].a, rows[i].d);
            bus(0, rows[i].a, 0);
            chk(q, rows[i].e);
        end
        bus(1, OFF_FAULT_MASK, 32'h0000_003F);
        access(3'd0);
        chk(32'(faults), 32'h1);
        chk(32'(irq), 32'h1);
        bus(0, OFF_FAULT_STATUS, 0);
        chk(q, 32'h0000_0001);
        bus(1, OFF_FAULT_STATUS, 32'h0000_0001);
        bus(0, OFF_FAULT_STATUS, 0);
        chk(q, 32'h0000_0000);
        chk(32'(irq), 32'h0);
        bus(1, OFF_FAULT_MASK, 32'h0000_0000);
        access(3'd1);
        chk(32'(irq), 32'h0);
        bus(1, OFF_FAULT_STATUS, 32'h0000_0002);
        // comparators enabled, then the access must not fault
        bus(1, OFF_RUN_GATE_SET1, 32'h0700_0000);
        ticks(2);
        chk(32'(unit_clk_en), 32'h38);
        access(3'd3);
        chk(32'(faults), 32'h2);
        bus(1, OFF_DEEP_SLEEP_GATE_SET0, 32'h0010_0008);
        deep_sleep_mode <= 1'b1;
        ticks(2);
        chk(32'(unit_clk_en), 32'h38);
        bus(1, OFF_RUN_CLOCK_CONFIG, 32'h0000_0001);
        ticks(2);
        chk(32'(unit_clk_en), 32'h05);
        access(3'd1);
        chk(32'(faults), 32'h3);
        deep_sleep_mode <= 1'b0;
        sleep_mode <= 1'b1;
        ticks(2);
        chk(32'(unit_clk_en), 32'h02);
        sleep_mode <= 1'b0;
        ticks(2);
        chk(32'(unit_clk_en), 32'h38);
        hresetn <= 1'b0;
        ticks(2);
        chk(32'(unit_clk_en), 32'h0);
        hresetn <= 1'b1;
        bus(0, OFF_DEEP_SLEEP_GATE_SET0, 0);
        chk(q, 32'h0000_0040);
        conclude();
    end
endmodule
`default_nettype wire
